//--- core/i2ms_seq.sv
// i2c master transaction sequencer with its transmit data fifo
// assumes open-drain sda/scl resolved outside, a pull-up when released,
// and control bits driven by logic on clk_sys
//
// Summary of operation
// - irq while enabled, tx irq enabled, data empty
// - 7-bit first byte: address high, bit0 direction
// - data copied into shift register after start
// - after first bit shifted, set data empty
// - sample sda in ack high phase
// - unrequested nack sets flag, clears ack, waits
// - stop after nack clears stop and flag
// - no nack flag when stop/start requested
// - final byte ends in stop or restart
// - stop request clears only after stop sent
// - after probe ack status reflects slave answer
// - 10-bit first byte bit0 clear, then start
// - 10-bit second byte loaded after first ack
// - tx irq per byte; last byte stop/restart
// - no start until requested and data written
// - data write clears data empty
// - stall before ack while data empty
// - 10-bit first byte pattern 11110 plus msbs
`timescale 1ns/1ns
`include "i2ms_regs.svh"

module i2ms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage words
   logic [AW-1:0] rd_reg; // read pointer
   logic [AW-1:0] wr_reg; // write pointer
   logic [AW:0] cnt_reg; // words held
   logic ready_reg; // not full; kept in a flop so the ready port is registered
   logic push;
   logic pop;

   // handshakes on both sides
   assign in_ready = ready_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage write, no reset needed
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   // pointers and count; flush drops stale data
   always_ff @(posedge clk_sys) begin
      if (reset || flush) begin
         rd_reg <= '0;
         wr_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
            // the last free word is being taken
            ready_reg <= (cnt_reg != (AW + 1)'(DEPTH - 1));
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
            ready_reg <= 1'b1;
         end
      end
   end
endmodule : i2ms_fifo

module i2ms_seq #(
   parameter int QUARTER_CYC = `I2MS_QUARTER_CYC,
   parameter int FIFO_DEPTH = `I2MS_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic controller_enable,
   input wire logic tx_irq_enable,
   input wire logic start_set,
   input wire logic stop_set,
   input wire logic flush,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   output logic data_wready,
   output logic start_req,
   output logic stop_req,
   output logic tx_data_empty,
   output logic ack_status,
   output logic nack_irq_flag,
   output logic ten_bit_addr,
   output logic busy,
   output logic irq,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_out,
   output logic scl_oe
);
   i2ms_pkg::i2ms_state_t state_reg; // sequencer state
   i2ms_pkg::i2ms_phase_t ph_reg; // quarter phase
   logic [2:0] bit_reg; // bit being sent
   logic [7:0] shift_reg; // outgoing byte
   logic [15:0] div_reg; // quarter-period divider
   logic tick; // one-cycle quarter enable
   logic sda_s1_reg; // synchroniser stage one
   logic sda_s2_reg; // synchronised sda
   logic start_reg; // start request
   logic stop_reg; // stop request
   logic tx_data_empty_reg; // data register empty
   logic ack_reg; // last ack seen
   logic nack_reg; // nack waiting for software
   logic ten_reg; // first byte was 10-bit prefix
   logic irq_reg; // interrupt line
   logic busy_reg; // transaction in progress
   logic sda_oe_reg; // pulling sda low
   logic scl_oe_reg; // pulling scl low
   logic f_valid; // fifo holds a byte
   logic [7:0] f_data; // fifo head
   logic f_pop; // take head into shift register
   logic stall; // hold before ack clock
   logic ack_end; // last quarter of ack bit
   logic sent_start; // start condition on the wire

   // true when a byte carries the 10-bit address prefix
   function automatic logic is_ten_prefix(input logic [7:0] b);
      is_ten_prefix = (b[7:3] == `I2MS_TEN_PREFIX);
   endfunction : is_ten_prefix

   // data register as a fifo; ready back-pressures the writer
   i2ms_fifo #(
      .WIDTH(`I2MS_BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .flush(flush),
      .in_valid(data_wr),
      .in_ready(data_wready),
      .in_data(data_wdata),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // stall only when more data is expected
   assign stall = !f_valid && !start_reg && !stop_reg;
   assign ack_end = tick && state_reg == i2ms_pkg::ST_ACK && ph_reg == 2'h3;
   assign sent_start = tick && state_reg == i2ms_pkg::ST_START && ph_reg == 2'h1;
   // head is taken at start end or after an ack that continues
   assign f_pop = f_valid && tick && ph_reg == 2'h3 &&
      (state_reg == i2ms_pkg::ST_START ||
       (state_reg == i2ms_pkg::ST_ACK && (ack_reg || start_reg || stop_reg) &&
        !start_reg && !stop_reg));

   // quarter-period divider; free running keeps it simple
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (div_reg == 16'(QUARTER_CYC - 1)) begin
         div_reg <= '0;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick <= 1'b0;
      end
   end

   // sda comes from the wire, two stages before use
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   // start and stop requests; set wins over a clear
   always_ff @(posedge clk_sys) begin
      if (reset || !controller_enable) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         if (start_set) begin
            start_reg <= 1'b1;
         end else if (sent_start) begin
            start_reg <= 1'b0;
         end
         if (stop_set) begin
            stop_reg <= 1'b1;
         end else if (tick && state_reg == i2ms_pkg::ST_STOP && ph_reg == 2'h3) begin
            stop_reg <= 1'b0;
         end
      end
   end

   // status flags
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_data_empty_reg <= `I2MS_TX_DATA_EMPTY_RST;
         ack_reg <= 1'b0;
         nack_reg <= 1'b0;
         ten_reg <= 1'b0;
      end else begin
         // empty after first bit leaves, or after a flush
         if ((tick && state_reg == i2ms_pkg::ST_SEND && ph_reg == 2'h3 &&
              bit_reg == 3'h7 && !f_valid) || flush) begin
            tx_data_empty_reg <= 1'b1;
         end else if (data_wr && data_wready) begin
            tx_data_empty_reg <= 1'b0;
         end
         // slave pulls sda low in the high quarter
         if (tick && state_reg == i2ms_pkg::ST_ACK && ph_reg == 2'h2) begin
            ack_reg <= !sda_s2_reg;
         end
         // nack only counts if no end was requested
         if (ack_end && !ack_reg && !start_reg && !stop_reg) begin
            nack_reg <= 1'b1;
         end else if ((tick && state_reg == i2ms_pkg::ST_STOP && ph_reg == 2'h3) ||
                      sent_start) begin
            nack_reg <= 1'b0;
         end
         // remember whether the first address byte was 10-bit
         if (f_pop && state_reg == i2ms_pkg::ST_START) begin
            ten_reg <= is_ten_prefix(f_data);
         end
      end
   end

   // interrupt and busy level
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         irq_reg <= controller_enable && ((tx_irq_enable && tx_data_empty_reg) || nack_reg);
         busy_reg <= state_reg != i2ms_pkg::ST_IDLE;
      end
   end

   // bus sequencer, one step per quarter period
   always_ff @(posedge clk_sys) begin
      if (reset || !controller_enable) begin
         state_reg <= i2ms_pkg::ST_IDLE;
         ph_reg <= 2'h0;
         bit_reg <= 3'h7;
         shift_reg <= 8'h00;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
      end else if (tick) begin
         ph_reg <= ph_reg + 2'h1;
         case (state_reg)
            i2ms_pkg::ST_IDLE: begin
               sda_oe_reg <= 1'b0;
               scl_oe_reg <= 1'b0;
               ph_reg <= 2'h0;
               if (start_reg && f_valid) begin
                  state_reg <= i2ms_pkg::ST_START;
               end
            end
            i2ms_pkg::ST_START: begin
               if (ph_reg == 2'h1) begin
                  sda_oe_reg <= 1'b1; // sda falls while scl high
               end else if (ph_reg == 2'h2) begin
                  scl_oe_reg <= 1'b1;
               end else if (ph_reg == 2'h3) begin
                  if (f_valid) begin
                     shift_reg <= f_data;
                     bit_reg <= 3'h7;
                     state_reg <= i2ms_pkg::ST_SEND;
                  end else begin
                     ph_reg <= 2'h3; // restart waits for data
                  end
               end
            end
            i2ms_pkg::ST_SEND: begin
               if (ph_reg == 2'h0) begin
                  sda_oe_reg <= !shift_reg[7]; // msb first
               end else if (ph_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (ph_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  bit_reg <= bit_reg - 3'h1;
                  if (bit_reg == 3'h0) begin
                     state_reg <= i2ms_pkg::ST_ACK;
                  end
               end
            end
            i2ms_pkg::ST_ACK: begin
               if (ph_reg == 2'h0) begin
                  sda_oe_reg <= 1'b0; // let the slave answer
                  if (stall) begin
                     ph_reg <= 2'h0;
                  end
               end else if (ph_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (ph_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  if (!ack_reg && !start_reg && !stop_reg) begin
                     state_reg <= i2ms_pkg::ST_WAIT;
                  end else if (stop_reg) begin
                     state_reg <= i2ms_pkg::ST_STOP;
                  end else if (start_reg) begin
                     state_reg <= i2ms_pkg::ST_RESTART;
                  end else if (f_valid) begin
                     shift_reg <= f_data;
                     bit_reg <= 3'h7;
                     state_reg <= i2ms_pkg::ST_SEND;
                  end else begin
                     ph_reg <= 2'h3; // flushed under us: hold
                  end
               end
            end
            i2ms_pkg::ST_WAIT: begin
               ph_reg <= 2'h0;
               if (stop_reg) begin
                  state_reg <= i2ms_pkg::ST_STOP;
               end else if (start_reg) begin
                  state_reg <= i2ms_pkg::ST_RESTART;
               end
            end
            i2ms_pkg::ST_STOP: begin
               if (ph_reg == 2'h0) begin
                  sda_oe_reg <= 1'b1;
               end else if (ph_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (ph_reg == 2'h2) begin
                  sda_oe_reg <= 1'b0; // sda rises while scl high
               end else begin
                  state_reg <= i2ms_pkg::ST_IDLE;
               end
            end
            i2ms_pkg::ST_RESTART: begin
               if (ph_reg == 2'h0) begin
                  sda_oe_reg <= 1'b0;
               end else if (ph_reg == 2'h1) begin
                  scl_oe_reg <= 1'b0;
               end else if (f_valid) begin
                  state_reg <= i2ms_pkg::ST_START;
                  ph_reg <= 2'h1; // next quarter pulls sda
               end else begin
                  ph_reg <= 2'h2;
               end
            end
            default: begin
               state_reg <= i2ms_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // outputs straight from flip-flops; pins only ever pull low
   assign start_req = start_reg;
   assign stop_req = stop_reg;
   assign tx_data_empty = tx_data_empty_reg;
   assign ack_status = ack_reg;
   assign nack_irq_flag = nack_reg;
   assign ten_bit_addr = ten_reg;
   assign busy = busy_reg;
   assign irq = irq_reg;
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign sda_oe = sda_oe_reg;
   assign scl_oe = scl_oe_reg;
endmodule : i2ms_seq

//--- include/i2ms_pkg.sv
// types shared by the i2c master sequencer
// assumes nothing beyond a systemverilog compiler
package i2ms_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_SEND = 3'b010,
      ST_ACK = 3'b011,
      ST_WAIT = 3'b100,
      ST_STOP = 3'b101,
      ST_RESTART = 3'b110
   } i2ms_state_t;
   // quarter-period phase within one scl cycle
   typedef logic [1:0] i2ms_phase_t;
endpackage : i2ms_pkg

//--- include/i2ms_regs.svh
// timing counts, field positions and reset values of the i2c master sequencer
// assumes a single system clock; all counts are in system clock cycles
`ifndef I2MS_REGS_SVH
`define I2MS_REGS_SVH
`define I2MS_CLK_PERIOD_NS 10
`define I2MS_SCL_PERIOD_NS 10000
// quarter scl period, rounded down
`define I2MS_QUARTER_CYC ((`I2MS_SCL_PERIOD_NS) / (4 * `I2MS_CLK_PERIOD_NS))
`define I2MS_BYTE_W 8
`define I2MS_FIFO_DEPTH 8
`define I2MS_RW_BIT 0
`define I2MS_TEN_PREFIX 5'h1e
`define I2MS_TX_DATA_EMPTY_RST 1'b1
`endif

//--- testbench/i2ms_seq_checker.sv
// port-level assertions for the i2c master sequencer
// assumes binding onto i2ms_seq, one clock domain on clk_sys
`timescale 1ns/1ns
module i2ms_seq_checker #(
   parameter int QUARTER_CYC = 4
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic controller_enable,
   input wire logic tx_irq_enable,
   input wire logic start_set,
   input wire logic flush,
   input wire logic data_wr,
   input wire logic data_wready,
   input wire logic start_req,
   input wire logic stop_req,
   input wire logic tx_data_empty,
   input wire logic ack_status,
   input wire logic nack_irq_flag,
   input wire logic irq,
   input wire logic sda_oe,
   input wire logic scl_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [7:0] since_stop; // cycles since sda let go while scl high
   // stop edge age; saturates so long idle spans never wrap
   always_ff @(posedge clk_sys) begin
      if (reset) since_stop <= 8'hff;
      else if (!scl_oe && $fell(sda_oe)) since_stop <= 8'h00;
      else if (since_stop != 8'hff) since_stop <= since_stop + 8'h01;
   end
   // start condition: sda pulled while scl released
   sequence start_cond;
      $rose(sda_oe) && !scl_oe;
   endsequence
   // failed acknowledge reported
   sequence nack_raise;
      $rose(nack_irq_flag);
   endsequence
   AST_TX_DATA_EMPTY_CLR: assert property (
      data_wr && data_wready && !flush |=> !tx_data_empty) else $error("write left empty set");
   AST_IRQ_TX: assert property (
      controller_enable && tx_irq_enable && tx_data_empty |=> irq) else $error("tx irq missing");
   AST_DIS_LINES: assert property (
      !controller_enable [*3] |-> !sda_oe && !scl_oe) else $error("lines driven while off");
   AST_DIS_START: assert property (
      !controller_enable && start_set |=> !start_req) else $error("start taken while off");
   AST_START_GATE: assert property (
      start_cond |-> $past(start_req) && !$past(tx_data_empty)) else $error("unrequested start");
   AST_ACK_SAMPLE: assert property (
      $changed(ack_status) |-> !$past(scl_oe)) else $error("ack moved with scl low");
   AST_NACK_NOREQ: assert property (
      nack_raise |-> !$past(stop_req) && !$past(start_req) && !ack_status)
      else $error("nack flag with request pending");
   AST_NACK_CLR: assert property (
      $fell(nack_irq_flag) && controller_enable |-> !stop_req && !start_req)
      else $error("nack cleared early");
   AST_STOP_SENT: assert property (
      $fell(stop_req) && controller_enable && $past(controller_enable)
      |-> since_stop <= 2 * QUARTER_CYC) else $error("stop request cleared before stop");
endmodule : i2ms_seq_checker

//--- testbench/i2ms_seq_tb.sv
// self-checking bench for the i2c master sequencer with a slave model
// assumes the checker and slave model files are compiled first
`timescale 1ns/1ns
module i2ms_seq_tb;
   localparam int QC = 4; // short quarter keeps a byte at 144 cycles
   logic clk_sys, reset, controller_enable, tx_irq_enable, start_set, stop_set, flush;
   logic data_wr, data_wready, start_req, stop_req, tx_data_empty, ack_status;
   logic nack_irq_flag, ten_bit_addr, busy, irq, sda_oe, scl_oe, sda_pull, ack_en;
   logic sda_o, scl_o; // open-drain drive levels, always low
   logic [7:0] data_wdata, slv_byte;
   int n_bytes, n_stops, fails, n_checks;
   wire sda = !(sda_oe | sda_pull); // open drain with pull-up
   wire scl = !scl_oe;
   i2ms_seq #(.QUARTER_CYC(QC), .FIFO_DEPTH(8)) uut (.clk_sys(clk_sys), .reset(reset),
      .controller_enable(controller_enable), .tx_irq_enable(tx_irq_enable),
      .start_set(start_set), .stop_set(stop_set), .flush(flush), .data_wr(data_wr),
      .data_wdata(data_wdata), .data_wready(data_wready), .start_req(start_req),
      .stop_req(stop_req), .tx_data_empty(tx_data_empty), .ack_status(ack_status),
      .nack_irq_flag(nack_irq_flag), .ten_bit_addr(ten_bit_addr), .busy(busy), .irq(irq),
      .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe), .scl_out(scl_o), .scl_oe(scl_oe));
   i2ms_slave_model u_slave (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(sda_pull),
      .last_byte(slv_byte), .n_bytes(n_bytes), .n_stops(n_stops));
   // one comparison; mismatches reported at once
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick
   // one-cycle control pulses, driven on the falling edge
   task automatic ctl(input logic st, input logic sp, input logic fl);
      @(negedge clk_sys);
      start_set = st;
      stop_set = sp;
      flush = fl;
      @(negedge clk_sys);
      {start_set, stop_set, flush} = 3'h0;
   endtask : ctl
   task automatic wr(input logic [7:0] b);
      @(negedge clk_sys);
      data_wr = 1'b1;
      data_wdata = b;
      @(negedge clk_sys);
      data_wr = 1'b0;
   endtask : wr
   // bounded wait on empty flag (0), stop request (1) or nack flag (2)
   task automatic wait_for(input int s, input logic v);
      logic cur;
      for (int i = 0; i < 3000; i++) begin
         cur = (s == 0) ? tx_data_empty : (s == 1) ? stop_req : nack_irq_flag;
         if (cur === v) return;
         @(negedge clk_sys);
      end
      fails++;
      $display("[ERR] wait %0d expected %b seen %b", s, v, cur);
   endtask : wait_for
   task automatic t_disabled;
      ctl(1'b1, 1'b0, 1'b0);
      tick(3);
      chk("start_req", start_req, 8'h00);
      chk("sda_oe", sda_oe, 8'h00);
      chk("scl_oe", scl_oe, 8'h00);
      chk("pin levels", {sda_o, scl_o}, 8'h00);
   endtask : t_disabled
   task automatic t_probe7(input logic ack, input logic [7:0] adr);
      int s0;
      s0 = n_stops;
      ack_en = ack;
      controller_enable = 1'b1;
      tick(1);
      tx_irq_enable = 1'b1;
      tick(2);
      chk("irq", irq, 8'h01);
      wr(adr);
      chk("tx_data_empty", tx_data_empty, 8'h00);
      tick(20);
      chk("busy", busy, 8'h00);
      tx_irq_enable = 1'b0;
      ctl(1'b1, 1'b1, 1'b0);
      wait_for(1, 1'b0);
      chk("ack", ack_status, ack);
      chk("nack", nack_irq_flag, 8'h00);
      chk("byte", slv_byte, adr);
      chk("stops", 8'(n_stops - s0), 8'h01);
   endtask : t_probe7
   task automatic t_write7;
      int b0, s0;
      b0 = n_bytes;
      s0 = n_stops;
      ack_en = 1'b1;
      tx_irq_enable = 1'b1;
      wr(8'ha2);
      ctl(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1);
      tick(1);
      chk("irq", irq, 8'h01);
      wr(8'h5a);
      wait_for(0, 1'b1);
      wr(8'hc3);
      wait_for(0, 1'b1);
      tick(400);
      chk("stall scl", scl_oe, 8'h01);
      chk("ack held", sda_pull, 8'h01);
      chk("bytes", 8'(n_bytes - b0), 8'h03);
      // a late write must release the stalled ack clock
      wr(8'h96);
      wait_for(0, 1'b1);
      tx_irq_enable = 1'b0;
      ctl(1'b0, 1'b1, 1'b0);
      wait_for(1, 1'b0);
      chk("byte", slv_byte, 8'h96);
      chk("stops", 8'(n_stops - s0), 8'h01);
      chk("ack", ack_status, 8'h01);
   endtask : t_write7
   task automatic t_nack_write;
      int s0;
      s0 = n_stops;
      ack_en = 1'b0;
      tx_irq_enable = 1'b1;
      wr(8'ha4);
      ctl(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1);
      wr(8'h11);
      wait_for(2, 1'b1);
      tick(50);
      chk("ack", ack_status, 8'h00);
      chk("irq", irq, 8'h01);
      chk("nack", nack_irq_flag, 8'h01);
      chk("scl held", scl_oe, 8'h01);
      tx_irq_enable = 1'b0;
      ctl(1'b0, 1'b1, 1'b1);
      wait_for(1, 1'b0);
      chk("nack", nack_irq_flag, 8'h00);
      chk("tx_data_empty", tx_data_empty, 8'h01);
      chk("stops", 8'(n_stops - s0), 8'h01);
   endtask : t_nack_write
   task automatic t_ten;
      int b0;
      b0 = n_bytes;
      ack_en = 1'b1;
      tx_irq_enable = 1'b1;
      wr(8'hf4);
      ctl(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1);
      wr(8'h3c);
      wait_for(0, 1'b1);
      tx_irq_enable = 1'b0;
      ctl(1'b0, 1'b1, 1'b0);
      wait_for(1, 1'b0);
      chk("ten", ten_bit_addr, 8'h01);
      chk("ack", ack_status, 8'h01);
      chk("byte", slv_byte, 8'h3c);
      chk("bytes", 8'(n_bytes - b0), 8'h02);
   endtask : t_ten
   // repeated start between two address phases, then stop
   task automatic t_restart;
      int b0, s0;
      b0 = n_bytes;
      s0 = n_stops;
      ack_en = 1'b1;
      tx_irq_enable = 1'b1;
      wr(8'ha2);
      ctl(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1);
      wr(8'ha4);
      ctl(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b1);
      chk("restart", start_req, 8'h00);
      tx_irq_enable = 1'b0;
      ctl(1'b0, 1'b1, 1'b0);
      wait_for(1, 1'b0);
      chk("ten", ten_bit_addr, 8'h00);
      chk("byte", slv_byte, 8'ha4);
      chk("bytes", 8'(n_bytes - b0), 8'h02);
      chk("stops", 8'(n_stops - s0), 8'h01);
   endtask : t_restart
   task automatic t_fifo;
      for (int i = 0; i < 8; i++) wr(8'(i));
      chk("wready", data_wready, 8'h00);
      wr(8'hee);
      ctl(1'b0, 1'b0, 1'b1);
      chk("tx_data_empty", tx_data_empty, 8'h01);
      chk("wready", data_wready, 8'h01);
   endtask : t_fifo
   task automatic complete_run;
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard, far above the expected run length
   initial begin
      #200000;
      fails++;
      complete_run();
   end
   initial begin
      {reset, controller_enable, tx_irq_enable, start_set, stop_set, flush} = 6'h20;
      {data_wr, ack_en} = 2'h0;
      data_wdata = 8'h00;
      fails = 0;
      n_checks = 0;
      tick(4);
      reset = 1'b0;
      chk("tx_data_empty", tx_data_empty, 8'h01);
      chk("irq", irq, 8'h00);
      t_disabled();
      t_probe7(1'b0, 8'ha0);
      t_probe7(1'b1, 8'ha0);
      t_write7();
      t_nack_write();
      t_ten();
      t_restart();
      t_fifo();
      complete_run();
   end
endmodule : i2ms_seq_tb
bind i2ms_seq i2ms_seq_checker #(.QUARTER_CYC(QUARTER_CYC)) u_chk (.clk_sys(clk_sys),
   .reset(reset), .controller_enable(controller_enable), .tx_irq_enable(tx_irq_enable),
   .start_set(start_set), .flush(flush), .data_wr(data_wr), .data_wready(data_wready),
   .start_req(start_req), .stop_req(stop_req), .tx_data_empty(tx_data_empty),
   .ack_status(ack_status), .nack_irq_flag(nack_irq_flag), .irq(irq), .sda_oe(sda_oe),
   .scl_oe(scl_oe));

//--- testbench/i2ms_slave_model.sv
// behavioural i2c slave: acks bytes on request, logs bytes and stops
// assumes open-drain wires resolved by the bench with pull-ups
`timescale 1ns/1ns
module i2ms_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   output logic sda_pull,
   output logic [7:0] last_byte,
   output int n_bytes,
   output int n_stops
);
   logic [7:0] shift_reg; // incoming bits, msb first
   int bit_cnt; // bits of current byte
   logic acking; // ack clock in progress
   initial begin
      sda_pull = 1'b0;
      acking = 1'b0;
      bit_cnt = 0;
      n_bytes = 0;
      n_stops = 0;
      last_byte = 8'h00;
      shift_reg = 8'h00;
   end
   // start or repeated start restarts byte framing
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bit_cnt = 0;
         acking = 1'b0;
      end
   end
   // stop: sda rises with scl high
   always @(posedge sda) begin
      if (scl === 1'b1) n_stops++;
   end
   // data sampled on scl rise
   always @(posedge scl) begin
      if (!acking && bit_cnt < 8) begin
         shift_reg = {shift_reg[6:0], sda};
         bit_cnt++;
      end
   end
   // ack after the 8th fall, released after the ack clock; held over any stall
   always @(negedge scl) begin
      if (acking) begin
         sda_pull = 1'b0;
         acking = 1'b0;
         bit_cnt = 0;
      end else if (bit_cnt == 8) begin
         sda_pull = ack_en;
         acking = 1'b1;
         last_byte = shift_reg;
         n_bytes++;
      end
   end
endmodule : i2ms_slave_model
